// [hw/adc_port_pkg.sv]
// Constants, timing counts and state codes for the converter output port.
// Assumes every user writes adc_port_pkg::name; nothing is imported.
package adc_port_pkg;

	// Result word layout.
	localparam int WORD_BITS = 20;
	localparam int IDX_BITS  = 5;
	localparam logic [IDX_BITS-1:0] BIT_MSB = 5'h13;
	localparam logic [IDX_BITS-1:0] BIT_LSB = 5'h00;
	localparam logic [WORD_BITS-1:0] WORD_RESET     = 20'h00000;
	localparam logic [WORD_BITS-1:0] BIPOLAR_OFFSET = 20'h80000;

	// Filter timing, counted in master clock cycles.
	localparam int FILTER_CYCLES = 1624;
	localparam int FLAG_LEAD     = 2;
	localparam int CNT_BITS      = 11;
	localparam logic [CNT_BITS-1:0] CNT_ZERO = 11'h000;
	localparam logic [CNT_BITS-1:0] CNT_ONE  = 11'h001;
	localparam logic [CNT_BITS-1:0] CNT_LAST =
		CNT_BITS'(FILTER_CYCLES - 1);
	localparam logic [CNT_BITS-1:0] CNT_FLAG =
		CNT_BITS'(FILTER_CYCLES - 1 - FLAG_LEAD);

	// Conversion sequencer states.
	typedef enum logic [2:0]
	{
		ST_STANDBY = 3'b001,
		ST_ALIGN   = 3'b010,
		ST_CONVERT = 3'b100
	} convert_cmd_state_type;

endpackage

// [hw/shift_link_if.sv]
// Carrier between the shift clock domain and the core domain.
// Assumes the two toggles are synchronised by the core before use.
`timescale 1ns/1ps
interface shift_link_if;

	logic rise_tgl; // Flips on every shift clock rising edge.
	logic fall_tgl; // Flips on every shift clock falling edge.

	modport link
	(
		output rise_tgl,
		output fall_tgl
	);

	modport core
	(
		input rise_tgl,
		input fall_tgl
	);

endinterface

// [hw/bit_sync.sv]
// Two-flop synchroniser for a group of independent level signals.
// Assumes each bit changes slowly compared with the destination clock.
`timescale 1ns/1ps
module bit_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             i_clk, // Destination clock.
	input  wire logic             i_rst, // Asynchronous reset, high.
	input  wire logic [WIDTH-1:0] i_d,   // Asynchronous levels.
	output logic      [WIDTH-1:0] o_q    // Synchronised levels.
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	// The first stage feeds only the second stage.
	always_comb
	begin
		next_meta = i_d;
		next_q    = meta;
	end

	// Both stages clear to zero under reset.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta <= '0;
			o_q  <= '0;
		end
		else
		begin
			meta <= next_meta;
			o_q  <= next_q;
		end
	end

endmodule

// [hw/link_shifter.sv]
// Shift clock domain: reports each rising and falling edge as a toggle.
// Assumes the core decides what each edge means; the clock may stop.
`timescale 1ns/1ps
module link_shifter
(
	input  wire logic  i_shift_clk, // Shift clock from the host.
	input  wire logic  i_rst,       // Asynchronous reset, high.
	shift_link_if.link link         // Edge toggles to the core.
);

	logic next_rise;
	logic next_fall;

	// A toggle per edge survives a stopped clock without a pending pulse.
	always_comb
	begin
		next_rise = ~link.rise_tgl;
		next_fall = ~link.fall_tgl;
	end

	// Rising edges, used to arm the shifter.
	always_ff @(posedge i_shift_clk or posedge i_rst)
	begin
		if (i_rst)
			link.rise_tgl <= 1'b0;
		else
			link.rise_tgl <= next_rise;
	end

	// Falling edges, used to advance the data bit.
	always_ff @(negedge i_shift_clk or posedge i_rst)
	begin
		if (i_rst)
			link.fall_tgl <= 1'b0;
		else
			link.fall_tgl <= next_fall;
	end

endmodule

// [hw/adc_serial_output_port.sv]
// Output side of the converter: filter timing, port update and shift-out.
// Assumes pins are asynchronous to i_clk and i_filter_word is on i_clk.
`timescale 1ns/1ps
module adc_serial_output_port
(
	input  wire logic        i_clk,              // Core clock, 200 MHz.
	input  wire logic        i_rst,              // Asynchronous reset.
	input  wire logic        i_master_clock_in,  // Master clock pin.
	input  wire logic        i_convert_cmd,      // Convert command pin.
	input  wire logic        i_polarity_select,  // High selects bipolar.
	input  wire logic        i_select_n,         // Port select, low.
	input  wire logic        i_shift_clk,        // Host shift clock.
	input  wire logic [19:0] i_filter_word,      // Raw filter result.
	output logic             o_word_available_n, // New word flag, low.
	output logic             o_serial_out,       // Serial data bit.
	output logic             o_serial_oe,        // Serial data enable.
	output logic             o_sample_phase,     // Capacitor switch phase.
	output logic             o_modulator_strobe, // Half-rate sample pulse.
	output logic             o_converting        // Conversion running.
);

	localparam int W = adc_port_pkg::WORD_BITS;

	shift_link_if link ();

	logic [3:0] pins_s;
	logic [1:0] edges_s;
	logic       mclk_s;
	logic       cmd_s;
	logic       sel_n_s;
	logic       pol_s;
	logic       rise_s;
	logic       fall_s;

	// The shift clock only clocks the edge reporter; all decisions are here.
	link_shifter u_link
	(
		.i_shift_clk (i_shift_clk),
		.i_rst       (i_rst),
		.link        (link.link)
	);

	bit_sync #(.WIDTH(4)) u_pin_sync
	(
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_master_clock_in, i_convert_cmd, i_select_n,
			i_polarity_select}),
		.o_q   (pins_s)
	);

	bit_sync #(.WIDTH(2)) u_edge_sync
	(
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({link.rise_tgl, link.fall_tgl}),
		.o_q   (edges_s)
	);

	// Synchronised pin levels and shift clock edge toggles.
	assign mclk_s  = pins_s[3];
	assign cmd_s   = pins_s[2];
	assign sel_n_s = pins_s[1];
	assign pol_s   = pins_s[0];
	assign rise_s  = edges_s[1];
	assign fall_s  = edges_s[0];

	// Edge detection on the synchronised levels.
	logic mclk_q;
	logic cmd_q;
	logic rise_q;
	logic fall_q;
	logic tick;
	logic start;
	logic rise_evt;
	logic fall_evt;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			mclk_q <= 1'b0;
			cmd_q  <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			mclk_q <= mclk_s;
			cmd_q  <= cmd_s;
			rise_q <= rise_s;
			fall_q <= fall_s;
		end
	end

	assign tick     = mclk_s & ~mclk_q;
	assign start    = cmd_s & ~cmd_q;
	assign rise_evt = rise_s ^ rise_q;
	assign fall_evt = fall_s ^ fall_q;

	// Conversion sequencer state.
	adc_port_pkg::convert_cmd_state_type          state;
	adc_port_pkg::convert_cmd_state_type          next_state;
	logic [adc_port_pkg::CNT_BITS-1:0]     cnt;
	logic [adc_port_pkg::CNT_BITS-1:0]     next_cnt;
	logic                                  phase;
	logic                                  next_phase;
	logic                                  next_sample_phase;
	logic                                  next_strobe;
	logic                                  flag_raise;
	logic                                  attempt;

	// Every timing figure counts master ticks, so the filter response and
	// its notches follow the master clock frequency.
	always_comb
	begin
		next_state        = state;
		next_cnt          = cnt;
		next_phase        = tick ? ~phase : phase;
		next_sample_phase = mclk_s;
		next_strobe       = tick & phase;
		flag_raise        = 1'b0;
		attempt           = 1'b0;
		unique case (state)
			adc_port_pkg::ST_STANDBY:
			begin
				if (start)
					next_state = adc_port_pkg::ST_ALIGN;
			end
			adc_port_pkg::ST_ALIGN:
			begin
				// Waiting for the half-rate boundary costs up to two cycles.
				if (start)
					next_state = adc_port_pkg::ST_ALIGN;
				else if (tick & phase)
				begin
					next_state = adc_port_pkg::ST_CONVERT;
					next_cnt   = adc_port_pkg::CNT_ZERO;
				end
			end
			adc_port_pkg::ST_CONVERT:
			begin
				// A fresh command abandons the conversion in progress.
				if (start)
					next_state = adc_port_pkg::ST_ALIGN;
				else if (tick)
				begin
					flag_raise = (cnt == adc_port_pkg::CNT_FLAG);
					if (cnt == adc_port_pkg::CNT_LAST)
					begin
						attempt    = 1'b1;
						next_cnt   = adc_port_pkg::CNT_ZERO;
						next_state = cmd_s ? adc_port_pkg::ST_CONVERT
							: adc_port_pkg::ST_STANDBY;
					end
					else
						next_cnt = cnt + adc_port_pkg::CNT_ONE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state              <= adc_port_pkg::ST_STANDBY;
			cnt                <= adc_port_pkg::CNT_ZERO;
			phase              <= 1'b0;
			o_sample_phase     <= 1'b0;
			o_modulator_strobe <= 1'b0;
		end
		else
		begin
			state              <= next_state;
			cnt                <= next_cnt;
			phase              <= next_phase;
			o_sample_phase     <= next_sample_phase;
			o_modulator_strobe <= next_strobe;
		end
	end

	assign o_converting = (state == adc_port_pkg::ST_CONVERT);

	// Serial port state.
	logic [W-1:0]                      word;
	logic [W-1:0]                      next_word;
	logic [adc_port_pkg::IDX_BITS-1:0] idx;
	logic [adc_port_pkg::IDX_BITS-1:0] next_idx;
	logic                              unread;
	logic                              next_unread;
	logic                              armed;
	logic                              next_armed;
	logic                              next_flag_n;
	logic                              next_serial_out;
	logic                              next_serial_oe;
	logic                              load;

	// Select is taken as it stands; it need not line up with the flag.
	// A deselect mid-word restarts the same word from its top bit.
	always_comb
	begin
		next_word   = word;
		next_idx    = idx;
		next_unread = unread;
		next_armed  = armed;
		next_flag_n = o_word_available_n;
		load        = attempt & (~unread | sel_n_s);
		if (sel_n_s)
		begin
			next_idx   = adc_port_pkg::BIT_MSB;
			next_armed = 1'b0;
		end
		if (rise_evt & unread & ~sel_n_s & o_serial_oe)
			next_armed = 1'b1;
		if (fall_evt & armed & unread & ~sel_n_s)
		begin
			if (idx == adc_port_pkg::BIT_LSB)
			begin
				next_unread = 1'b0;
				next_armed  = 1'b0;
				next_flag_n = 1'b1;
			end
			else
				next_idx = idx - 5'h01;
		end
		if (flag_raise)
			next_flag_n = 1'b1;
		if (load)
		begin
			next_word   = pol_s ? i_filter_word + adc_port_pkg::BIPOLAR_OFFSET
				: i_filter_word;
			next_unread = 1'b1;
			next_idx    = adc_port_pkg::BIT_MSB;
			next_armed  = 1'b0;
			next_flag_n = 1'b0;
		end
		next_serial_oe  = next_unread & ~sel_n_s;
		next_serial_out = next_serial_oe & next_word[next_idx];
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			word               <= adc_port_pkg::WORD_RESET;
			idx                <= adc_port_pkg::BIT_MSB;
			unread             <= 1'b0;
			armed              <= 1'b0;
			o_word_available_n <= 1'b1;
			o_serial_out       <= 1'b0;
			o_serial_oe        <= 1'b0;
		end
		else
		begin
			word               <= next_word;
			idx                <= next_idx;
			unread             <= next_unread;
			armed              <= next_armed;
			o_word_available_n <= next_flag_n;
			o_serial_out       <= next_serial_out;
			o_serial_oe        <= next_serial_oe;
		end
	end

	// Helper: master ticks since the conversion proper began.
	logic [adc_port_pkg::CNT_BITS-1:0] ticks_seen;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			ticks_seen <= adc_port_pkg::CNT_ZERO;
		else if (state != adc_port_pkg::ST_CONVERT || attempt)
			ticks_seen <= adc_port_pkg::CNT_ZERO;
		else if (tick)
			ticks_seen <= ticks_seen + adc_port_pkg::CNT_ONE;
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	property p_filter_count;
		attempt |-> ticks_seen == adc_port_pkg::CNT_LAST;
	endproperty
	a_filter_count: assert property (p_filter_count)
		else $error("update attempt not after 1624 master cycles");

	property p_flag_early;
		attempt |-> o_word_available_n;
	endproperty
	a_flag_early: assert property (p_flag_early)
		else $error("flag not high before update attempt");

	property p_hold_busy;
		(attempt && unread && !sel_n_s) |=> $stable(word) && unread;
	endproperty
	a_hold_busy: assert property (p_hold_busy)
		else $error("busy selected port was overwritten");

	property p_load_low;
		(attempt && (!unread || sel_n_s)) |=> !o_word_available_n && unread;
	endproperty
	a_load_low: assert property (p_load_low)
		else $error("load did not drive flag low");

	property p_msb_first;
		($fell(sel_n_s) && unread && !attempt)
			|=> o_serial_oe && o_serial_out == word[W-1];
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("top bit not presented on select");

	property p_early_fall;
		(fall_evt && !armed && !attempt) |=> $stable(idx) || sel_n_s;
	endproperty
	a_early_fall: assert property (p_early_fall)
		else $error("fall before arming moved the bit");

	property p_shift_down;
		(fall_evt && armed && unread && !sel_n_s && !attempt
			&& idx != adc_port_pkg::BIT_LSB) |=> idx == $past(idx) - 5'h01;
	endproperty
	a_shift_down: assert property (p_shift_down)
		else $error("falling edge did not move one bit down");

	property p_empty;
		(fall_evt && armed && unread && !sel_n_s && !attempt
			&& idx == adc_port_pkg::BIT_LSB)
			|=> !o_serial_oe && o_word_available_n && !unread;
	endproperty
	a_empty: assert property (p_empty)
		else $error("port not emptied after last bit");

	property p_polarity;
		(load && pol_s) |=> word == $past(i_filter_word)
			+ adc_port_pkg::BIPOLAR_OFFSET;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("bipolar word lacks offset");

	property p_released;
		sel_n_s |=> !o_serial_oe;
	endproperty
	a_released: assert property (p_released)
		else $error("serial output driven while deselected");

endmodule

// [tb/host_reader.sv]
// Host-side model that selects the port and shifts one word out.
// Assumes the bench raises i_start once per read and waits for o_done.
`timescale 1ns/1ps
module host_reader
(
	input  wire logic  i_start,      // Begin one read.
	input  wire logic  i_early,      // Shift clock high before arming.
	input  wire logic  i_serial_out, // Serial data bit.
	input  wire logic  i_serial_oe,  // Serial data enable.
	output logic       o_select_n,   // Port select, low.
	output logic       o_shift_clk,  // Shift clock, 80 ns.
	output logic       o_done,       // Word complete pulse.
	output logic       o_oe_ok,      // Enable seen high at every bit.
	output logic       o_end_oe,     // Enable after the final fall.
	output logic [19:0] o_word       // Word as shifted in.
);
	// The clock stands low outside frames, as a real host would leave it.
	initial
	begin
		o_select_n = 1'b1;
		o_shift_clk = 1'b0;
		o_done = 1'b0;
		o_oe_ok = 1'b0;
		o_end_oe = 1'b0;
		o_word = 20'h00000;
		forever
		begin
			@(posedge i_start);
			#3.7;
			o_oe_ok = 1'b1;
			o_shift_clk = i_early;
			o_select_n = 1'b0;
			#500;
			if (i_early)
			begin
				o_shift_clk = 1'b0;
				#40;
			end
			// Bits are taken at each rise, well after the prior fall.
			for (int i = 0; i < 20; i++)
			begin
				o_shift_clk = 1'b1;
				o_word = {o_word[18:0], i_serial_out};
				o_oe_ok = o_oe_ok & i_serial_oe;
				#40;
				o_shift_clk = 1'b0;
				#40;
			end
			o_end_oe = i_serial_oe;
			o_select_n = 1'b1;
			#10;
			o_done = 1'b1;
			#10;
			o_done = 1'b0;
		end
	end
endmodule

// [tb/adc_serial_output_port_test.sv]
// Bench for the converter output port with a host reader model.
// Assumes host_reader drives select and shift clock; words checked at done.
`timescale 1ns/1ps
module adc_serial_output_port_test;
	logic        i_clk;
	logic        i_rst;
	logic        mclk;
	logic        cmd;
	logic        pol;
	logic [19:0] fword;
	logic        sel_n;
	logic        sclk;
	logic        flag_n;
	logic        sdo;
	logic        soe;
	logic        start;
	logic        early;
	logic        h_done;
	logic        oe_ok;
	logic        end_oe;
	logic [19:0] h_word;
	logic        convert_cmd;
	logic        strobe;
	logic        sphase;
	logic [31:0] seed;
	logic [19:0] exp_q[$];
	int          fails;
	int          samples_checked;
	int          ticks;
	int          t0;
	int          strobes;
	int          phase_falls;
	int          s0;
	int          p0;

	adc_serial_output_port dut_u
	(
		.i_clk              (i_clk),
		.i_rst              (i_rst),
		.i_master_clock_in  (mclk),
		.i_convert_cmd      (cmd),
		.i_polarity_select  (pol),
		.i_select_n         (sel_n),
		.i_shift_clk        (sclk),
		.i_filter_word      (fword),
		.o_word_available_n (flag_n),
		.o_serial_out       (sdo),
		.o_serial_oe        (soe),
		.o_sample_phase     (sphase),
		.o_modulator_strobe (strobe),
		.o_converting       (convert_cmd)
	);

	host_reader host_u
	(
		.i_start      (start),
		.i_early      (early),
		.i_serial_out (sdo),
		.i_serial_oe  (soe),
		.o_select_n   (sel_n),
		.o_shift_clk  (sclk),
		.o_done       (h_done),
		.o_oe_ok      (oe_ok),
		.o_end_oe     (end_oe),
		.o_word       (h_word)
	);

	// Clocks; the master clock is offset so its edges never meet i_clk.
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial
	begin
		mclk = 1'b0;
		#7.3;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) ticks++;

	// Strobes are taken at the core edge; phase falls come half a master cycle
	// after a tick, clear of the flag edge, so neither count races the flag watcher.
	always @(posedge i_clk) if (strobe === 1'b1) strobes++;
	always @(negedge sphase) phase_falls++;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic test_done();
		$display("Compared %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check_word(string what, logic [19:0] e, logic [19:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic check_count(string what, int e, int g);
		check_word(what, 20'(e), 20'(g));
	endtask

	// Bipolar results carry the half-scale offset, wrapping at 20 bits.
	function automatic logic [19:0] coded(logic [19:0] w, logic p);
		return p ? w + adc_port_pkg::BIPOLAR_OFFSET : w;
	endfunction

	// New word and polarity go in after a load, so the next load sees them.
	task automatic next_word(logic p);
		@(negedge i_clk);
		seed = lfsr_next(seed);
		fword = seed[19:0];
		pol = p;
	endtask

	task automatic read_word(logic [19:0] e, logic er);
		exp_q.push_back(e);
		@(negedge i_clk);
		early = er;
		start = 1'b1;
		@(posedge h_done);
		@(negedge i_clk);
		start = 1'b0;
	endtask

	// Watcher: each finished read is compared with the oldest note.
	initial
	begin
		forever
		begin
			@(posedge h_done);
			check_word("word", exp_q.pop_front(), h_word);
			check_word("oe", 20'h1, 20'(oe_ok));
			check_word("end_oe", 20'h0, 20'(end_oe));
			check_word("oe_idle", 20'h0, 20'(soe));
			check_word("flag", 20'h1, 20'(flag_n));
		end
	end

	initial
	begin
		#450000;
		fails++;
		test_done();
	end

	initial
	begin
		logic [19:0] w2;
		i_rst = 1'b1;
		cmd = 1'b0;
		pol = 1'b0;
		start = 1'b0;
		early = 1'b0;
		ticks = 0;
		seed = 32'h240ad3e1;
		fword = seed[19:0];
		repeat (10) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_clk);
		cmd = 1'b1;
		@(posedge convert_cmd);
		t0 = ticks;
		@(negedge flag_n);
		check_count("filter_ticks", 1624, ticks - t0);
		check_word("convert_cmd", 20'h1, 20'(convert_cmd));
		s0 = strobes;
		p0 = phase_falls;
		// Read the first word, then let the emptied port take the next.
		read_word(fword, 1'b0);
		next_word(1'b1);
		@(negedge flag_n);
		// One full conversion: a strobe each second tick, a phase per tick.
		check_count("strobes", adc_port_pkg::FILTER_CYCLES / 2, strobes - s0);
		check_count("phase", adc_port_pkg::FILTER_CYCLES, phase_falls - p0);
		// Unread word and host away: flag lead, then deselected load.
		w2 = coded(fword, 1'b1);
		next_word(1'b1);
		w2 = coded(fword, 1'b1);
		@(posedge flag_n);
		t0 = ticks;
		@(negedge flag_n);
		check_count("lead_ticks", 2, ticks - t0);
		next_word(1'b0);
		// Selecting inside the lead blocks the update; old word is read.
		@(posedge flag_n);
		read_word(w2, 1'b0);
		@(negedge flag_n);
		read_word(fword, 1'b1);
		repeat (20) @(negedge i_clk);
		test_done();
	end
endmodule
